// ---- hot_swap_capability_regs.vh ----
// constants for the hot swap capability structure: offsets, field positions,
// reset values and the priming sample count.
// assumes the configuration port presents byte addresses and dword data.
`ifndef HOT_SWAP_CAPABILITY_REGS_VH
`define HOT_SWAP_CAPABILITY_REGS_VH

// byte address of the dword that holds the whole structure
`define HS_CAP_ADDR 8'h50

// byte lanes inside that dword
`define HS_LANE_CAP_ID 0
`define HS_LANE_NEXT_PTR 1
`define HS_LANE_CSR 2
`define HS_LANE_RSVD 3

// fixed and reset values
`define HS_CAP_ID_VALUE 8'h06
`define HS_NEXT_PTR_RESET 8'h00
`define HS_PROG_IF_VALUE 2'h0
`define HS_RSVD_VALUE 8'h00

// fields of the control/status byte
`define HS_INS_BIT 7
`define HS_EXT_BIT 6
`define HS_PI_HI_BIT 5
`define HS_PI_LO_BIT 4
`define FRONT_PANEL_LED_OUT_BIT 3
`define HS_PIE_BIT 2
`define HS_EIM_BIT 1
`define HS_DHA_BIT 0

// reset values of the writable and status bits
`define HS_INS_RESET 1'h0
`define HS_EXT_RESET 1'h0
`define FRONT_PANEL_LED_OUT_RESET 1'h0
`define HS_EIM_RESET 1'h0

// bits that always read zero in the basic programming interface
`define HS_PIE_VALUE 1'h0
`define HS_DHA_VALUE 1'h0

// samples taken after reset before the switch level is trusted
`define HS_PRIME_COUNT 2'h3

`endif

// ---- level_sync.v ----
// two-flop synchroniser for one asynchronous level.
// assumes the input may change at any time relative to ref_clk_i;
// only the second flop is meant to be read by other logic.
module level_sync
(
  input wire ref_clk_i,
  input wire srst_i,
  input wire async_i,
  output wire sync_o
);

  reg meta_reg;
  reg sync_reg;

  // first flop feeds only the second one
  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule

// ---- hot_swap_capability.v ----
// hot swap capability structure: capability id, next pointer and the
// control/status byte, plus switch edge detection, enum line and led drive.
// assumes a single-cycle configuration access port on the pci clock, a
// front-panel switch that is asynchronous, and an external open-drain
// buffer that resolves the enum line from enum_o and enum_oe_n_o.
`include "hot_swap_capability_regs.vh"

// Operation
// - capability id reads 06h, writes ignored
// - next pointer 00h, read-only, rom loadable
// - insertion flag resets 0, write-one clears
// - extraction flag resets 0, write-one clears only
// - programming interface field reads 00b, read-only
// - led bit read/write, reset 0, 1=on
// - pending indicator always reads 0
// - mask bit read/write, reset 0, masks enum
// - device hiding arm always reads 0
// - switch rising edge sets insertion, asserts enum
// - switch falling edge sets extraction, asserts enum
// - led pin follows the led bit continuously
module hot_swap_capability
(
  input wire ref_clk_i,
  input wire srst_i,
  input wire [7:0] cfg_addr_i,
  input wire [3:0] cfg_be_i,
  input wire cfg_wr_i,
  input wire cfg_rd_i,
  input wire [31:0] cfg_wdata_i,
  output wire [31:0] cfg_rdata_o,
  output wire cfg_ack_o,
  input wire rom_load_i,
  input wire [7:0] rom_next_ptr_i,
  input wire front_panel_switch_in_i,
  output wire front_panel_led_out_o,
  input wire enum_i,
  output wire enum_o,
  output wire enum_oe_n_o,
  output wire enum_line_low_o
);

  // synchronised copies of the two pins
  wire switch_sync;
  wire enum_sync;

  // switch edge detection state
  reg [1:0] prime_cnt_reg;
  reg [1:0] prime_cnt_next;
  reg primed_reg;
  reg primed_next;
  reg switch_prev_reg;
  reg switch_prev_next;
  wire switch_rise;
  wire switch_fall;

  // control/status storage
  reg insertion_flag_reg;
  reg insertion_flag_next;
  reg extraction_flag_reg;
  reg extraction_flag_next;
  reg led_on_ctrl_reg;
  reg led_on_ctrl_next;
  reg enum_event_mask_reg;
  reg enum_event_mask_next;
  reg [7:0] hot_swap_next_ptr_reg;
  reg [7:0] hot_swap_next_ptr_next;

  // bus answer and pin drive
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg ack_reg;
  reg ack_next;
  reg led_out_reg;
  reg enum_oe_n_reg;
  reg enum_oe_n_next;
  reg enum_low_reg;
  reg enum_drv_reg;

  // decode of the access
  wire cap_hit;
  wire csr_write;
  wire next_write;
  wire [7:0] csr_wbyte;
  wire ins_clear;
  wire ext_clear;
  wire [7:0] swap_ctrl_status;
  wire [31:0] cap_dword;

  // switch and enum line both come from outside the clock domain
  level_sync u_switch_sync
  (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .async_i(front_panel_switch_in_i),
    .sync_o(switch_sync)
  );

  level_sync u_enum_sync
  (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .async_i(enum_i),
    .sync_o(enum_sync)
  );

  // priming: the synchroniser holds reset zeros for two cycles, so the
  // previous level is loaded from the pin without an event until then;
  // this keeps a board powered up with the switch closed from raising a
  // false insertion on every reset
  always @*
  begin
    prime_cnt_next = prime_cnt_reg;
    primed_next = primed_reg;
    if (!primed_reg)
    begin
      if (prime_cnt_reg == `HS_PRIME_COUNT)
      begin
        primed_next = 1'b1;
      end
      else
      begin
        prime_cnt_next = prime_cnt_reg + 2'h1;
      end
    end
  end

  // previous switch level, tracked even while unprimed
  always @*
  begin
    switch_prev_next = switch_sync;
  end

  // edges seen only once the pipeline carries real samples
  assign switch_rise = primed_reg & switch_sync & ~switch_prev_reg;
  assign switch_fall = primed_reg & ~switch_sync & switch_prev_reg;

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      prime_cnt_reg <= 2'h0;
      primed_reg <= 1'b0;
      switch_prev_reg <= 1'b0;
    end
    else
    begin
      prime_cnt_reg <= prime_cnt_next;
      primed_reg <= primed_next;
      switch_prev_reg <= switch_prev_next;
    end
  end

  // access decode: one dword holds id, pointer and control/status
  assign cap_hit = ({cfg_addr_i[7:2], 2'b00} == `HS_CAP_ADDR);
  assign csr_write = cap_hit & cfg_wr_i & cfg_be_i[`HS_LANE_CSR];
  assign next_write = cap_hit & cfg_wr_i & cfg_be_i[`HS_LANE_NEXT_PTR];
  assign csr_wbyte = cfg_wdata_i[8*`HS_LANE_CSR +: 8];
  assign ins_clear = csr_write & csr_wbyte[`HS_INS_BIT];
  assign ext_clear = csr_write & csr_wbyte[`HS_EXT_BIT];

  // insertion flag: a switch edge in the clearing cycle still wins
  always @*
  begin
    insertion_flag_next = insertion_flag_reg;
    if (switch_rise)
    begin
      insertion_flag_next = 1'b1;
    end
    else if (ins_clear)
    begin
      insertion_flag_next = 1'b0;
    end
  end

  // extraction flag: writing zero leaves it alone
  always @*
  begin
    extraction_flag_next = extraction_flag_reg;
    if (switch_fall)
    begin
      extraction_flag_next = 1'b1;
    end
    else if (ext_clear)
    begin
      extraction_flag_next = 1'b0;
    end
  end

  // plain read/write bits of the control/status byte
  always @*
  begin
    led_on_ctrl_next = led_on_ctrl_reg;
    enum_event_mask_next = enum_event_mask_reg;
    if (csr_write)
    begin
      led_on_ctrl_next = csr_wbyte[`FRONT_PANEL_LED_OUT_BIT];
      enum_event_mask_next = csr_wbyte[`HS_EIM_BIT];
    end
  end

  // next pointer: bus writes to its lane are dropped, only rom loads it
  always @*
  begin
    hot_swap_next_ptr_next = hot_swap_next_ptr_reg;
    if (rom_load_i)
    begin
      hot_swap_next_ptr_next = rom_next_ptr_i;
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      insertion_flag_reg <= `HS_INS_RESET;
      extraction_flag_reg <= `HS_EXT_RESET;
      led_on_ctrl_reg <= `FRONT_PANEL_LED_OUT_RESET;
      enum_event_mask_reg <= `HS_EIM_RESET;
      hot_swap_next_ptr_reg <= `HS_NEXT_PTR_RESET;
    end
    else
    begin
      insertion_flag_reg <= insertion_flag_next;
      extraction_flag_reg <= extraction_flag_next;
      led_on_ctrl_reg <= led_on_ctrl_next;
      enum_event_mask_reg <= enum_event_mask_next;
      hot_swap_next_ptr_reg <= hot_swap_next_ptr_next;
    end
  end

  // read view of the control/status byte; constant bits are wired in
  assign swap_ctrl_status[`HS_INS_BIT] = insertion_flag_reg;
  assign swap_ctrl_status[`HS_EXT_BIT] = extraction_flag_reg;
  assign swap_ctrl_status[`HS_PI_HI_BIT:`HS_PI_LO_BIT] = `HS_PROG_IF_VALUE;
  assign swap_ctrl_status[`FRONT_PANEL_LED_OUT_BIT] = led_on_ctrl_reg;
  assign swap_ctrl_status[`HS_PIE_BIT] = `HS_PIE_VALUE;
  assign swap_ctrl_status[`HS_EIM_BIT] = enum_event_mask_reg;
  assign swap_ctrl_status[`HS_DHA_BIT] = `HS_DHA_VALUE;

  // whole dword as software sees it
  assign cap_dword[8*`HS_LANE_CAP_ID +: 8] = `HS_CAP_ID_VALUE;
  assign cap_dword[8*`HS_LANE_NEXT_PTR +: 8] = hot_swap_next_ptr_reg;
  assign cap_dword[8*`HS_LANE_CSR +: 8] = swap_ctrl_status;
  assign cap_dword[8*`HS_LANE_RSVD +: 8] = `HS_RSVD_VALUE;

  // read data is registered; disabled lanes read zero so a byte read of
  // the status byte cannot be confused by neighbouring fields
  always @*
  begin
    rdata_next = 32'h0000_0000;
    ack_next = 1'b0;
    if (cap_hit && (cfg_rd_i || cfg_wr_i))
    begin
      ack_next = 1'b1;
    end
    if (cap_hit && cfg_rd_i)
    begin
      rdata_next[7:0] = cfg_be_i[0] ? cap_dword[7:0] : 8'h00;
      rdata_next[15:8] = cfg_be_i[1] ? cap_dword[15:8] : 8'h00;
      rdata_next[23:16] = cfg_be_i[2] ? cap_dword[23:16] : 8'h00;
      rdata_next[31:24] = cfg_be_i[3] ? cap_dword[31:24] : 8'h00;
    end
  end

  // enum drive: low while any flag is set and the event is unmasked;
  // clearing both flags or setting the mask lets the line float again
  always @*
  begin
    enum_oe_n_next = 1'b1;
    if ((insertion_flag_reg || extraction_flag_reg) && !enum_event_mask_reg)
    begin
      enum_oe_n_next = 1'b0;
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      rdata_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      led_out_reg <= `FRONT_PANEL_LED_OUT_RESET;
      enum_oe_n_reg <= 1'b1;
      enum_low_reg <= 1'b0;
      enum_drv_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      led_out_reg <= led_on_ctrl_reg;
      enum_oe_n_reg <= enum_oe_n_next;
      // synchroniser resets to zero while the idle line is high, so the
      // view is held off until priming ends to avoid a false low report
      enum_low_reg <= primed_reg & ~enum_sync;
      enum_drv_reg <= 1'b0; // open-drain data never drives high
    end
  end

  // outputs; the open-drain data is a constant low from a held flop
  assign cfg_rdata_o = rdata_reg;
  assign cfg_ack_o = ack_reg;
  assign front_panel_led_out_o = led_out_reg;
  assign enum_o = enum_drv_reg;
  assign enum_oe_n_o = enum_oe_n_reg;
  assign enum_line_low_o = enum_low_reg;

endmodule

// ---- hot_swap_capability_props.sv ----
// port checker for the hot swap capability structure
// assumes it is bound to every instance of hot_swap_capability
module hot_swap_capability_props
(
  input wire ref_clk_i,
  input wire srst_i,
  input wire [7:0] cfg_addr_i,
  input wire [3:0] cfg_be_i,
  input wire cfg_wr_i,
  input wire cfg_rd_i,
  input wire [31:0] cfg_wdata_i,
  input wire [31:0] cfg_rdata_o,
  input wire cfg_ack_o,
  input wire rom_load_i,
  input wire [7:0] rom_next_ptr_i,
  input wire front_panel_switch_in_i,
  input wire front_panel_led_out_o,
  input wire enum_o,
  input wire enum_oe_n_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // access to the capability dword
  wire hit = cfg_addr_i[7:2] == 6'h14;

  id_read_a: assert property (cfg_rd_i && hit && cfg_be_i[0] |=> cfg_rdata_o[7:0] == 8'h06)
    else $error("capability id read wrong");
  ack_hit_only_a: assert property (!((cfg_rd_i || cfg_wr_i) && hit) |=> !cfg_ack_o)
    else $error("answer without a mapped access");
  idle_zero_a: assert property (!cfg_ack_o |-> cfg_rdata_o == 32'h0)
    else $error("read data outside the answer cycle");
  fixed_zero_a: assert property (cfg_ack_o |-> cfg_rdata_o[31:24] == 8'h00 &&
    cfg_rdata_o[21:20] == 2'h0 && !cfg_rdata_o[18] && !cfg_rdata_o[16])
    else $error("fixed csr field not zero");
  // the pin lags the written bit by two register stages
  led_pin_a: assert property (cfg_wr_i && hit && cfg_be_i[2] |=> ##1
    front_panel_led_out_o == $past(cfg_wdata_i[19], 2))
    else $error("led pin does not follow written bit");
  // both the read data and the pin reflect the flags before the taking edge
  enum_drive_a: assert property (cfg_ack_o && $past(cfg_rd_i && cfg_be_i[2]) |-> enum_oe_n_o ==
    !((cfg_rdata_o[23] || cfg_rdata_o[22]) && !cfg_rdata_o[17]))
    else $error("enum drive disagrees with flags and mask");
  enum_low_a: assert property (enum_o == 1'b0)
    else $error("enum data not low");
  rom_ptr_a: assert property (rom_load_i ##1 (cfg_rd_i && hit && cfg_be_i[1] && !rom_load_i) |=>
    cfg_rdata_o[15:8] == $past(rom_next_ptr_i, 2))
    else $error("next pointer not loaded from rom");

  cover property (cfg_ack_o && $past(cfg_rd_i));
  cover property ($rose(front_panel_switch_in_i));
  cover property ($fell(enum_oe_n_o));
endmodule

bind hot_swap_capability hot_swap_capability_props hot_swap_capability_props_i (.*);

// ---- front_panel_model.sv ----
// front-panel switch and the shared enum line at the board edge
// assumes a pull-up on the enum line and no other board pulling it
module front_panel_model
(
  input wire logic seat_i,
  input wire logic enum_drv_i,
  input wire logic enum_oe_n_i,
  output wire logic switch_o,
  output wire logic enum_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // switch closes once the board is seated; released line floats up
  assign switch_o = seat_i;
  assign enum_line_o = enum_oe_n_i ? 1'b1 : enum_drv_i;
endmodule

// ---- hot_swap_capability_bench.sv ----
// self-checking bench for the hot swap capability structure
// assumes a one-cycle answer on the configuration port
module hot_swap_capability_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [3:0] cfg_be_i = 4'h0;
  logic cfg_wr_i = 1'b0;
  logic cfg_rd_i = 1'b0;
  logic [31:0] cfg_wdata_i = 32'h0;
  logic rom_load_i = 1'b0;
  logic [7:0] rom_next_ptr_i = 8'h00;
  logic seated = 1'b0;
  logic [7:0] ptr_exp = 8'h00;
  wire [31:0] cfg_rdata_o;
  wire cfg_ack_o, sw, led, enum_i, enum_o, enum_oe_n_o, line_low;
  int num_errors = 0;
  int checks_done = 0;

  always #20 ref_clk_i = ~ref_clk_i;

  hot_swap_capability hot_swap_capability_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o),
    .rom_load_i(rom_load_i), .rom_next_ptr_i(rom_next_ptr_i), .front_panel_switch_in_i(sw),
    .front_panel_led_out_o(led), .enum_i(enum_i), .enum_o(enum_o),
    .enum_oe_n_o(enum_oe_n_o), .enum_line_low_o(line_low));
  front_panel_model front_panel_model_i (.seat_i(seated), .enum_drv_i(enum_o),
    .enum_oe_n_i(enum_oe_n_o), .switch_o(sw), .enum_line_o(enum_i));

  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access; returns just after the answer edge; also ends a rom strobe
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] data,
    input logic [3:0] be);
    @(posedge ref_clk_i);
    rom_load_i <= 1'b0;
    cfg_addr_i <= addr;
    cfg_be_i <= be;
    cfg_wr_i <= wr;
    cfg_rd_i <= !wr;
    cfg_wdata_i <= data;
    @(posedge ref_clk_i);
    cfg_wr_i <= 1'b0;
    cfg_rd_i <= 1'b0;
    #1;
  endtask

  task automatic csr_read(input logic [7:0] csr);
    access(1'b0, 8'h50, 32'h0, 4'hf);
    chk("ack", 1, cfg_ack_o);
    chk("dword", {8'h00, csr, ptr_exp, 8'h06}, cfg_rdata_o);
  endtask

  // ones on the other lanes prove they are ignored
  task automatic csr_write(input logic [7:0] csr);
    access(1'b1, 8'h50, {8'hff, csr, 16'hffff}, 4'hf);
    chk("ack", 1, cfg_ack_o);
  endtask

  task automatic set_seat(input logic v);
    @(posedge ref_clk_i);
    seated <= v;
    repeat (9) @(posedge ref_clk_i);
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    csr_read(8'h00);
    csr_write(8'hff);
    csr_read(8'h0a);
    chk("led", 1, led);
    csr_write(8'h00);
    repeat (8) @(posedge ref_clk_i);
    chk("led", 0, led);
    set_seat(1'b1);
    csr_read(8'h80);
    chk("enum_oe_n", 0, enum_oe_n_o);
    chk("line_low", 1, line_low);
    csr_write(8'h40);
    csr_read(8'h80);
    csr_write(8'h80);
    csr_read(8'h00);
    chk("enum_oe_n", 1, enum_oe_n_o);
    csr_write(8'h02);
    set_seat(1'b0);
    csr_read(8'h42);
    chk("enum_oe_n", 1, enum_oe_n_o);
    chk("line_low", 0, line_low);
    csr_write(8'h40);
    csr_read(8'h00);
    // strobe lands the cycle just before the read, the access ends it
    @(posedge ref_clk_i);
    rom_next_ptr_i <= 8'h5c;
    rom_load_i <= 1'b1;
    ptr_exp = 8'h5c;
    csr_read(8'h00);
    // a write without the status lane must leave the led bit alone
    csr_write(8'h08);
    access(1'b1, 8'h50, 32'h0000_0000, 4'hb);
    access(1'b0, 8'h50, 32'h0, 4'h4);
    chk("lane2 read", 32'h0008_0000, cfg_rdata_o);
    access(1'b0, 8'h54, 32'h0, 4'hf);
    chk("ack", 0, cfg_ack_o);
    tally_and_finish;
  end

  // the sequence needs under 150 cycles
  initial
  begin
    #20000;
    num_errors++;
    tally_and_finish;
  end
endmodule
